// *** hw/sac_pkg.sv ***
package sac_pkg;

  // ----------------------------------------------------------------
  // conversion framing
  // ----------------------------------------------------------------
  localparam int unsigned SAC_CONV_EDGES  = 16;     // clock cycles per conversion
  localparam int unsigned SAC_TRACK_CYC   = 3;      // track cycles at conversion start
  localparam int unsigned SAC_HOLD_CYC    = 13;     // hold and convert cycles
  localparam int unsigned SAC_RESULT_BITS = 12;     // result width
  localparam int unsigned SAC_CTRL_BITS   = 8;      // control byte width

  // falling edge numbers inside one conversion
  localparam logic [4:0] SAC_FALL_FIRST   = 5'h01;  // track entry
  localparam logic [4:0] SAC_FALL_HOLD    = 5'h04;  // hold entry, last leading zero
  localparam logic [4:0] SAC_FALL_LAST    = 5'h10;  // result lsb, power down after

  // rising edge index (0 based) of the last control bit
  localparam logic [3:0] SAC_RISE_CTRL_LAST = 4'h7;

  // ----------------------------------------------------------------
  // channel select control byte layout
  // ----------------------------------------------------------------
  localparam int unsigned SAC_CHAN_MSB    = 5;      // chan_sel_bit2
  localparam int unsigned SAC_CHAN_LSB    = 3;      // chan_sel_bit0
  localparam logic [2:0]  SAC_CHAN_RESET  = 3'h0;   // analog_channel_zero
  localparam logic [7:0]  SAC_CTRL_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // successive approximation
  // ----------------------------------------------------------------
  localparam logic [11:0] SAC_SAR_FIRST   = 12'h800;
  localparam logic [11:0] SAC_SAR_RESET   = 12'h000;

  // pin synchroniser reset levels: select high, clock low, data low
  localparam logic [2:0]  SAC_PIN_RESET   = 3'h1;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SAC_IDLE,    // select high, clock gated off
    SAC_WAIT,    // select low, waiting for first clock fall
    SAC_TRACK,   // acquiring input
    SAC_HOLD,    // converting and shifting result
    SAC_DOWN     // after last fall, powered down until next conversion
  } sac_state_type;

endpackage

// *** hw/sac_pin_sync.sv ***
module sac_pin_sync
  import sac_pkg::*;
#(
  parameter int unsigned        WIDTH     = 3,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] levelPrev
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] hist;
  } sac_sync_type;

  sac_sync_type r_q;
  sac_sync_type r_d;

  // two stage synchroniser plus one history stage for edge detection
  always_comb begin
    r_d      = r_q;
    r_d.meta = pinIn;
    r_d.sync = r_q.meta;
    r_d.hist = r_q.sync;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= {RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      r_q <= r_d;
    end
  end

  assign level     = r_q.sync;
  assign levelPrev = r_q.hist;

endmodule

// *** hw/sac_conv_ctrl.sv ***
// Summary of operation
// R01: track the input for three cycles
// R02: hold and convert for thirteen cycles
// R03: select low frames; its edges bound frames
// R04: host gives multiples of sixteen rising edges
// R05: output driven only while select low
// R06: clock ignored while select high
// R07: four zeros, then result msb first
// R08: each sixteen edges, track again, hold at four
// R09: select falls, clock high: wait next fall
// R10: select falls, clock low: fall counts first
// R11: any order of select and clock falls
// R12: control byte on first eight rising edges
// R13: captured channel used by next conversion
// R14: host sends fresh control each conversion
// R15: channel field is bits five to three
// R16: channel code is plain binary index
// R17: channel zero after power up
// R18: result is straight binary code
// R19: powered while select low, down after fall 16
// R20: select may rise at any clock level
// R21: each sixteen edge group loads next channel
// R22: host samples output on rising edges
module sac_conv_ctrl
  import sac_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        selectInN,
  input  wire logic        shiftClk,
  input  wire logic        serialIn,
  output logic             serialOut,
  output logic             serialOutOe,
  input  wire logic        compAbove,
  output logic [11:0]      dacCode,
  output logic [2:0]       chanSel,
  output logic             trackActive,
  output logic             holdActive,
  output logic             powerUp
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    sac_state_type state;
    logic [4:0]    fallCnt;    // falling edge number in this conversion
    logic [3:0]    riseCnt;    // rising edge index, wraps every sixteen
    logic [7:0]    ctrlShift;  // channel select control shifter
    logic [2:0]    nextChan;   // channel for the next conversion
    logic [2:0]    convChan;   // channel of the running conversion
    logic [11:0]   sarCode;    // trial and result code
    logic [11:0]   sarMask;    // bit under trial
    logic          sdo;
    logic          oe;
  } sac_regs_type;

  sac_regs_type r_q;
  sac_regs_type r_d;

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pinLevel;
  logic [2:0] pinPrev;

  sac_pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (SAC_PIN_RESET)
  ) u_pin_sync (
    .clock     (clock),
    .rst_b     (rst_b),
    .pinIn     ({serialIn, shiftClk, selectInN}),
    .level     (pinLevel),
    .levelPrev (pinPrev)
  );

  logic csHigh;
  logic sclkLow;
  logic sclkRise;
  logic sclkFall;
  logic dinBit;

  // levels and edges of the synchronised pins
  assign csHigh   = pinLevel[0];
  assign sclkLow  = !pinLevel[1];
  assign sclkRise = pinLevel[1] && !pinPrev[1];
  assign sclkFall = !pinLevel[1] && pinPrev[1];
  assign dinBit   = pinLevel[2];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pick the channel index out of a control byte
  function automatic logic [2:0] chanField(input logic [7:0] ctrl);
    chanField = ctrl[SAC_CHAN_MSB:SAC_CHAN_LSB];  // other bits ignored [R15] [R16]
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [7:0]  ctrlNext;
  logic [4:0]  fallNext;

  assign ctrlNext = {r_q.ctrlShift[6:0], dinBit};
  assign fallNext = r_q.fallCnt + 5'h01;

  always_comb begin
    r_d = r_q;
    if (csHigh) begin
      // select high ends the frame and gates the clock [R03] [R06] [R20]
      r_d.state   = SAC_IDLE;
      r_d.oe      = 1'b0;      // output released [R05]
      r_d.sdo     = 1'b0;
      r_d.fallCnt = 5'h00;
    end else begin
      r_d.oe = 1'b1;           // output driven while select low [R05]
      if (r_q.state == SAC_IDLE) begin
        // frame start; control bits count from here [R03] [R12]
        r_d.riseCnt = 4'h0;
        if (sclkLow) begin
          // select fall stands for the first clock fall [R10] [R11]
          r_d.state    = SAC_TRACK;
          r_d.fallCnt  = SAC_FALL_FIRST;
          r_d.convChan = r_q.nextChan;
          r_d.sdo      = 1'b0;
        end else begin
          r_d.state = SAC_WAIT;  // track begins on next fall [R09]
        end
      end else begin
        // rising edges: control byte capture per sixteen edge group
        if (sclkRise) begin
          r_d.riseCnt = r_q.riseCnt + 4'h1;
          if (r_q.riseCnt <= SAC_RISE_CTRL_LAST) begin
            r_d.ctrlShift = ctrlNext;  // first eight rises [R12] [R21]
          end
          if (r_q.riseCnt == SAC_RISE_CTRL_LAST) begin
            r_d.nextChan = chanField(ctrlNext);  // applies next time [R13] [R21]
          end
        end
        // falling edges: phase and data output
        if (sclkFall) begin
          unique case (r_q.state)
            SAC_WAIT, SAC_DOWN: begin
              // new conversion starts in track [R08] [R09]
              r_d.state    = SAC_TRACK;
              r_d.fallCnt  = SAC_FALL_FIRST;
              r_d.convChan = r_q.nextChan;
              r_d.sdo      = 1'b0;
            end
            SAC_TRACK: begin
              r_d.fallCnt = fallNext;
              r_d.sdo     = 1'b0;    // leading zeros [R07]
              if (fallNext == SAC_FALL_HOLD) begin
                // three track cycles done, sample held [R01] [R08]
                r_d.state   = SAC_HOLD;
                r_d.sarCode = SAC_SAR_FIRST;
                r_d.sarMask = SAC_SAR_FIRST;
              end
            end
            SAC_HOLD: begin
              // one approximation step per fall, bit goes out msb first [R02] [R07] [R18]
              r_d.fallCnt = fallNext;
              r_d.sdo     = compAbove;
              r_d.sarCode = (compAbove ? r_q.sarCode : (r_q.sarCode & ~r_q.sarMask))
                            | (r_q.sarMask >> 1);
              r_d.sarMask = r_q.sarMask >> 1;
              if (fallNext == SAC_FALL_LAST) begin
                r_d.state = SAC_DOWN;  // power down until next first fall [R19]
              end
            end
            SAC_IDLE: begin
              r_d.state = SAC_IDLE;
            end
          endcase
        end
      end
    end
  end

  // state register; channel zero after power up [R17]
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{state:     SAC_IDLE,
               fallCnt:   5'h00,
               riseCnt:   4'h0,
               ctrlShift: SAC_CTRL_RESET,
               nextChan:  SAC_CHAN_RESET,
               convChan:  SAC_CHAN_RESET,
               sarCode:   SAC_SAR_RESET,
               sarMask:   SAC_SAR_RESET,
               sdo:       1'b0,
               oe:        1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // phase decode and analog controls
  assign serialOut   = r_q.sdo;
  assign serialOutOe = r_q.oe;
  assign dacCode     = r_q.sarCode;
  assign chanSel     = r_q.convChan;
  assign trackActive = (r_q.state == SAC_TRACK);
  assign holdActive  = (r_q.state == SAC_HOLD);
  assign powerUp     = (r_q.state == SAC_WAIT) || trackActive || holdActive;  // [R19]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // last track fall while select stays low
  sequence s_last_track_fall;
    trackActive && sclkFall && !csHigh && (r_q.fallCnt == 5'h03);
  endsequence

  // last hold fall while select stays low
  sequence s_last_hold_fall;
    holdActive && sclkFall && !csHigh && (r_q.fallCnt == 5'h0f);
  endsequence

  // eighth rising edge of a group while select stays low
  sequence s_ctrl_last_rise;
    (r_q.state != SAC_IDLE) && sclkRise && !csHigh && (r_q.riseCnt == 4'h7);
  endsequence

  a_track_three_cycles: assert property (s_last_track_fall |=> holdActive && (r_q.fallCnt == 5'h04)) // [R01]
    else $error("hold not entered at fourth fall");

  a_hold_thirteen: assert property (s_last_hold_fall |=> (r_q.state == SAC_DOWN) && !powerUp) // [R02]
    else $error("conversion not finished at sixteenth fall");

  a_out_enable_cs: assert property (csHigh |=> !serialOutOe && !powerUp) // [R05]
    else $error("output driven or powered while select high");

  a_clock_gated: assert property (csHigh && (r_q.state == SAC_IDLE) |=> // [R06]
    $stable(r_q.nextChan) && $stable(r_q.ctrlShift))
    else $error("clock edge changed state while select high");

  a_leading_zeros: assert property (trackActive && sclkFall && !csHigh |=> !serialOut) // [R07]
    else $error("leading zero missing");

  a_result_bit: assert property (holdActive && sclkFall && !csHigh |=> serialOut == $past(compAbove)) // [R07]
    else $error("result bit not the comparator decision");

  a_retrack_group: assert property ((r_q.state == SAC_DOWN) && sclkFall && !csHigh |=> // [R08]
    trackActive && (r_q.fallCnt == 5'h01))
    else $error("track not reentered after sixteen edges");

  a_start_clk_high: assert property ((r_q.state == SAC_IDLE) && !csHigh && !sclkLow |=> // [R09]
    (r_q.state == SAC_WAIT) ##0 (r_q.state == SAC_WAIT || trackActive) [*2])
    else $error("early track with clock high");

  a_start_clk_low: assert property ((r_q.state == SAC_IDLE) && !csHigh && sclkLow |=> // [R10]
    trackActive && (r_q.fallCnt == 5'h01))
    else $error("select fall not taken as first fall");

  a_chan_capture: assert property (s_ctrl_last_rise |=> r_q.nextChan == $past(r_q.ctrlShift[4:2])) // [R15]
    else $error("channel field captured from wrong bits");

  a_chan_next_conv: assert property ($rose(trackActive) |-> chanSel == $past(r_q.nextChan)) // [R13]
    else $error("conversion not using previously captured channel");

  // control byte capture, rise counting and select abort
  sequence s_group_rise;
    (r_q.state != SAC_IDLE) && sclkRise && !csHigh;
  endsequence

  // rising edge that still belongs to the control byte
  sequence s_ctrl_rise;
    (r_q.state != SAC_IDLE) && sclkRise && !csHigh && (r_q.riseCnt <= SAC_RISE_CTRL_LAST);
  endsequence

  a_frame_start_count: assert property ((r_q.state == SAC_IDLE) && !csHigh |=> r_q.riseCnt == 4'h0) // [R12]
    else $error("rise count not cleared at frame start");

  a_ctrl_shift_in: assert property (s_ctrl_rise |=> // [R12]
    r_q.ctrlShift == {$past(r_q.ctrlShift[6:0]), $past(dinBit)})
    else $error("control bit not shifted in");

  a_ctrl_hold_late: assert property (s_group_rise ##0 (r_q.riseCnt > SAC_RISE_CTRL_LAST) |=> // [R12]
    $stable(r_q.ctrlShift))
    else $error("control byte changed after eighth rise");

  a_rise_wrap: assert property (s_group_rise |=> r_q.riseCnt == $past(r_q.riseCnt) + 4'h1) // [R21]
    else $error("rise count not advanced");

  a_select_abort: assert property (csHigh |=> (r_q.state == SAC_IDLE) && (r_q.fallCnt == 5'h00)) // [R03]
    else $error("frame not ended by select high");

  // conversion datapath, channel and wait state
  a_sar_first_trial: assert property (s_last_track_fall |=> dacCode == SAC_SAR_FIRST) // [R02]
    else $error("first trial code wrong at hold entry");

  a_sar_mask_walk: assert property (holdActive && sclkFall && !csHigh |=> // [R02]
    r_q.sarMask == ($past(r_q.sarMask) >> 1))
    else $error("trial bit not stepped down");

  a_conv_chan_steady: assert property (holdActive |=> $stable(chanSel)) // [R13]
    else $error("channel changed during conversion");

  a_wait_quiet: assert property ((r_q.state == SAC_WAIT) |-> !serialOut && powerUp) // [R09]
    else $error("waiting for first fall but output high or powered down");

endmodule

// *** sim/sac_host_model.sv ***
module sac_host_model
  import sac_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  sdoWire,
  output logic       selectInN,
  output logic       shiftClk,
  output logic       serialIn,
  output int         riseCnt,
  output logic       inFrame
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // host serial controller, shift clock of 12 system clocks
  // ----------------------------------------------------------------
  localparam int HALF = 6;  // system clocks per half period

  logic [15:0] rxWord [0:2];

  // idle levels: deselected, clock standing low
  initial begin
    selectInN = 1'b1;
    shiftClk  = 1'b0;
    serialIn  = 1'b0;
    riseCnt   = 0;
    inFrame   = 1'b0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge clock);
  endtask

  // clock wiggles while deselected
  task automatic toggle_idle(input int n);
    serialIn <= 1'b1;  // data high so a leaking clock would load channel seven
    for (int i = 0; i < 2 * n; i++) begin
      wait_half();
      shiftClk <= ~shiftClk;
    end
    wait_half();
  endtask

  // one frame of nConv conversions, 16 rises each
  task automatic run_frame(input int nConv, input bit clkHigh, input logic [7:0] c0, c1, c2);
    logic [23:0] ctrlAll;
    int          last;
    ctrlAll = {c2, c1, c0};
    last = nConv * 16 - 1;
    @(posedge clock);
    riseCnt <= 0;
    if (clkHigh) begin
      shiftClk <= 1'b1;  // select may fall at either clock level
      wait_half();
    end
    selectInN <= 1'b0;  // frame opens
    inFrame   <= 1'b1;
    if (clkHigh) begin
      wait_half();
      shiftClk <= 1'b0;
    end
    for (int k = 0; k <= last; k++) begin
      if (k % 16 < 8) begin
        serialIn <= ctrlAll[(k / 16) * 8 + 7 - k % 16];  // fresh byte each group, msb first
      end else begin
        serialIn <= ~serialIn;
      end
      wait_half();
      shiftClk <= 1'b1;  // whole groups of 16 rises
      riseCnt  <= riseCnt + 1;
      rxWord[k / 16] = {rxWord[k / 16][14:0], sdoWire};  // sample output at rise
      wait_half();
      if (k != last) begin
        shiftClk <= 1'b0;
      end
    end
    selectInN <= 1'b1;  // release with clock high
    inFrame   <= 1'b0;
    wait_half();
    shiftClk <= 1'b0;
    serialIn <= ~serialIn;
    wait_half();
  endtask
endmodule

// *** sim/sac_conv_ctrl_tb.sv ***
module sac_conv_ctrl_tb
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // clock, reset, wiring
  // ----------------------------------------------------------------
  logic        clock;
  logic        rst_b;
  logic        compAbove;
  logic        selectInN;
  logic        shiftClk;
  logic        serialIn;
  logic        serialOut;
  logic        serialOutOe;
  logic [11:0] dacCode;
  logic [2:0]  chanSel;
  logic        trackActive;
  logic        holdActive;
  logic        powerUp;
  wire logic   sdoWire;
  int          riseCnt;
  logic        inFrame;
  int          errors;
  int          samplesChecked;
  logic [15:0] phaseSeen;
  logic [2:0]  expChan;
  logic [11:0] chanLevel [0:7] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001, 12'hffe, 12'h555, 12'haaa};

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  assign sdoWire = serialOutOe ? serialOut : 1'bz;  // select acts as output enable

  // comparator of the analog core: input at or above trial code
  always @(posedge clock) begin
    compAbove <= chanLevel[chanSel] >= dacCode;
  end

  sac_conv_ctrl dut (.clock(clock), .rst_b(rst_b), .selectInN(selectInN), .shiftClk(shiftClk),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe), .compAbove(compAbove),
    .dacCode(dacCode), .chanSel(chanSel), .trackActive(trackActive), .holdActive(holdActive),
    .powerUp(powerUp));

  sac_host_model host (.clock(clock), .sdoWire(sdoWire), .selectInN(selectInN), .shiftClk(shiftClk),
    .serialIn(serialIn), .riseCnt(riseCnt), .inFrame(inFrame));

  // ----------------------------------------------------------------
  // comparison and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // phase seen at every host rise inside a frame: oe, track, hold, power
  always @(riseCnt) begin
    if (inFrame && riseCnt > 0) begin
      phaseSeen = {12'h000, serialOutOe, trackActive, holdActive, powerUp};
      if ((riseCnt - 1) % 16 < 3) begin
        check(phaseSeen, 16'h000d);
      end else if ((riseCnt - 1) % 16 < 15) begin
        check(phaseSeen, 16'h000b);
      end else begin
        check(phaseSeen, 16'h0008);
      end
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_idle();
    check({11'h000, serialOutOe, powerUp, chanSel}, 16'h0000);
    host.toggle_idle(8);
    check({9'h000, serialOutOe, powerUp, chanSel, trackActive, holdActive}, 16'h0000);
    $display("test_reset_idle done");
  endtask

  task automatic test_first_conv();
    host.run_frame(1, 1'b0, 8'h28, 8'h00, 8'h00);
    check(host.rxWord[0], {4'h0, chanLevel[0]});
    check({15'h0000, serialOutOe}, 16'h0000);
    expChan = 3'h5;
    $display("test_first_conv done");
  endtask

  task automatic test_channel_walk();
    for (int c = 0; c < 8; c++) begin
      host.run_frame(1, c[0], {2'b11, c[2:0], 3'b111}, 8'h00, 8'h00);
      check(host.rxWord[0], {4'h0, chanLevel[expChan]});
      expChan = c[2:0];
    end
    $display("test_channel_walk done");
  endtask

  task automatic test_continuous();
    host.run_frame(3, 1'b1, 8'hd7, 8'h38, 8'h4e);
    check(host.rxWord[0], {4'h0, chanLevel[expChan]});
    check(host.rxWord[1], {4'h0, chanLevel[2]});
    check(host.rxWord[2], {4'h0, chanLevel[7]});
    host.run_frame(1, 1'b0, 8'h00, 8'h00, 8'h00);
    check(host.rxWord[0], {4'h0, chanLevel[1]});
    $display("test_continuous done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    samplesChecked = 0;
    rst_b = 1'b0;
    expChan = 3'h0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    test_reset_idle();
    test_first_conv();
    test_channel_walk();
    test_continuous();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    test_done();
  end
endmodule
